//--- ettp_defs.vh
`ifndef ETTP_DEFS_VH
`define ETTP_DEFS_VH
// ----------------------------------------------------------------
// packet header bytes
// ----------------------------------------------------------------
// commit header, single byte packet
`define ETTP_HDR_COMMIT   8'h0E
// exact-match header, selector sits in bits [1:0]
`define ETTP_HDR_EXACT    8'h90
// short-address header
`define ETTP_HDR_SHORT    8'hA0
// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
// address selector codes
`define ETTP_SEL_ENTRY0   2'h0
`define ETTP_SEL_ENTRY1   2'h1
`define ETTP_SEL_ENTRY2   2'h2
// element select codes
`define ETTP_ELEM_EXC     2'h1
`define ETTP_ELEM_TGT_EXC 2'h2
// exception type codes that carry meaning
`define ETTP_TYPE_RESET   5'h00
`define ETTP_TYPE_HALT    5'h01
`define ETTP_TYPE_FIQ     5'h0F
`define ETTP_TYPE_IMPL0   5'h10
`define ETTP_TYPE_TXFAIL  5'h18
// ----------------------------------------------------------------
// widths and sizes
// ----------------------------------------------------------------
`define ETTP_BYTE_W       8
`define ETTP_FIFO_DEPTH   32
`define ETTP_FIFO_AW      5
`define ETTP_PKT_BYTES    7
`define ETTP_MORE_BIT     7
`endif

//--- ettp_encoder.v
`include "ettp_defs.vh"

// ----------------------------------------------------------------
// fifo between packer and sink
// ----------------------------------------------------------------
module ettp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // storage, no reset needed
  reg [AW-1:0]    wr_ptr_ff;          // next write slot
  reg [AW-1:0]    rd_ptr_ff;          // next read slot
  reg [AW:0]      count_ff;           // words held

  // full and empty come from the count, so they never lie
  assign wr_ready_out = (count_ff != DEPTH[AW:0]);
  assign rd_valid_out = (count_ff != {(AW+1){1'b0}});
  assign rd_data_out  = mem_ff[rd_ptr_ff];
  wire   do_wr        = wr_valid_in & wr_ready_out; // push this edge
  wire   do_rd        = rd_valid_out & rd_ready_in; // pop this edge

  // storage write
  always @(posedge clk_in)
  begin
    if (do_wr)
      mem_ff[wr_ptr_ff] <= wr_data_in;
  end

  // pointers and count
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      if (do_rd)
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      // simultaneous push and pop leaves the count alone
      if (do_wr & ~do_rd)
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      else if (do_rd & ~do_wr)
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule

// ----------------------------------------------------------------
// packet encoder top
// ----------------------------------------------------------------
module ettp_encoder (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        ev_valid_in,     // event offered
  output wire        ev_ready_out,    // event may be taken
  input  wire        ev_is_commit_in, // 1 commit, 0 exception
  input  wire [4:0]  exc_type_in,     // exception type
  input  wire [1:0]  elem_sel_in,     // element select
  input  wire [31:0] ret_addr_in,     // preferred return address
  input  wire [31:0] hist0_in,        // address history entry 0
  input  wire [31:0] hist1_in,        // address history entry 1
  input  wire [31:0] hist2_in,        // address history entry 2
  output wire        drop_out,        // event refused as reserved
  output wire        byte_valid_out,  // stream byte valid
  input  wire        byte_ready_in,   // sink takes byte
  output wire [7:0]  byte_data_out    // stream byte
);
  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b01; // waiting for an event
  localparam ST_SEND = 2'b10; // pushing packet bytes

  reg [1:0]  state_ff;     // one-hot state
  reg [1:0]  nxt_state;
  reg [55:0] pkt_ff;       // packed bytes, next byte lowest
  reg [55:0] nxt_pkt;
  reg [2:0]  len_ff;       // bytes left to push
  reg [2:0]  nxt_len;
  reg        rdy_ff;       // event ready, registered
  reg        nxt_rdy;
  reg        drop_ff;      // one-cycle refusal pulse
  reg        nxt_drop;
  reg        ovalid_ff;    // output stage valid
  reg [7:0]  obyte_ff;     // output stage byte
  wire       push_valid;
  wire       push_ready;
  wire       pop_valid;
  wire [7:0] pop_data;
  wire       pop_take;
  // ----------------------------------------------------------------
  // exception field checks and address compression
  // ----------------------------------------------------------------
  reg        type_ok;      // type code is one we may emit
  reg        elem_ok;      // element select is defined
  reg [1:0]  sel;          // matching history entry
  reg        exact;        // exact match found
  reg [29:0] addr_w;       // return address without low bits
  reg [29:0] diff_w;       // bits differing from entry 0
  reg [2:0]  n_addr;       // address bytes in short packet
  reg [39:0] addr_bytes;   // five address bytes, flagged

  always @*
  begin
    case (exc_type_in)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07: type_ok = 1'b1;
      5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h0F:               type_ok = 1'b1;
      default: type_ok = ({exc_type_in[4:3], 3'h0} == `ETTP_TYPE_IMPL0);
    endcase
    type_ok = type_ok & (exc_type_in != `ETTP_TYPE_TXFAIL);
    elem_ok = (elem_sel_in == `ETTP_ELEM_EXC) || (elem_sel_in == `ETTP_ELEM_TGT_EXC);
    exact = 1'b1;
    sel   = `ETTP_SEL_ENTRY0;
    if (ret_addr_in == hist0_in)
      sel = `ETTP_SEL_ENTRY0;
    else if (ret_addr_in == hist1_in)
      sel = `ETTP_SEL_ENTRY1;
    else if (ret_addr_in == hist2_in)
      sel = `ETTP_SEL_ENTRY2;
    else
      exact = 1'b0;
    addr_w = ret_addr_in[31:2];
    diff_w = addr_w ^ hist0_in[31:2];
    n_addr = (diff_w[29:28] != 2'h0)  ? 3'h5 :
             (diff_w[27:21] != 7'h00) ? 3'h4 :
             (diff_w[20:14] != 7'h00) ? 3'h3 :
             (diff_w[13:7]  != 7'h00) ? 3'h2 : 3'h1;
    // byte k flags more when n_addr exceeds k+1
    addr_bytes = {1'b0, 5'h00, addr_w[29:28],
                  (n_addr > 3'h4), addr_w[27:21],
                  (n_addr > 3'h3), addr_w[20:14],
                  (n_addr > 3'h2), addr_w[13:7],
                  (n_addr > 3'h1), addr_w[6:0]};
  end

  // ----------------------------------------------------------------
  // packer state machine
  // ----------------------------------------------------------------
  // a whole packet is loaded at once, then shifted out a byte a cycle
  always @*
  begin
    nxt_state = state_ff;
    nxt_pkt   = pkt_ff;
    nxt_len   = len_ff;
    nxt_rdy   = rdy_ff;
    nxt_drop  = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (ev_valid_in && rdy_ff)
        begin
          nxt_rdy = 1'b0;
          if (ev_is_commit_in)
          begin
            nxt_pkt   = {48'h0, `ETTP_HDR_COMMIT};
            nxt_len   = 3'h1;
            nxt_state = ST_SEND;
          end
          else if (!type_ok || !elem_ok)
          begin
            nxt_drop = 1'b1;
            nxt_rdy  = 1'b1;
          end
          else if (exact)
          begin
            nxt_pkt   = {40'h0, elem_sel_in, 1'b0, exc_type_in,
                         (`ETTP_HDR_EXACT | {6'h00, sel})};
            nxt_len   = 3'h2;
            nxt_state = ST_SEND;
          end
          else
          begin
            nxt_pkt   = {addr_bytes, elem_sel_in, 1'b0, exc_type_in,
                         `ETTP_HDR_SHORT};
            nxt_len   = n_addr + 3'h2;
            nxt_state = ST_SEND;
          end
        end
      end
      ST_SEND:
      begin
        if (push_ready)
        begin
          nxt_pkt = {8'h00, pkt_ff[55:8]};
          nxt_len = len_ff - 3'h1;
          if (len_ff == 3'h1)
          begin
            nxt_state = ST_IDLE;
            nxt_rdy   = 1'b1;
          end
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_rdy   = 1'b1;
      end
    endcase
  end

  // state registers
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff <= ST_IDLE;
      pkt_ff   <= 56'h0;
      len_ff   <= 3'h0;
      rdy_ff   <= 1'b1;
      drop_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pkt_ff   <= nxt_pkt;
      len_ff   <= nxt_len;
      rdy_ff   <= nxt_rdy;
      drop_ff  <= nxt_drop;
    end
  end
  assign push_valid = state_ff[1];
  // ----------------------------------------------------------------
  // byte fifo and output stage
  // ----------------------------------------------------------------
  // full fifo stalls the packer, which stalls ev_ready_out
  ettp_fifo #(
    .WIDTH (`ETTP_BYTE_W),
    .DEPTH (`ETTP_FIFO_DEPTH),
    .AW    (`ETTP_FIFO_AW)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .wr_valid_in  (push_valid),
    .wr_ready_out (push_ready),
    .wr_data_in   (pkt_ff[7:0]),
    .rd_valid_out (pop_valid),
    .rd_ready_in  (pop_take),
    .rd_data_out  (pop_data)
  );
  // refill the output stage when empty or being taken
  assign pop_take = pop_valid & (~ovalid_ff | byte_ready_in);
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ovalid_ff <= 1'b0;
      obyte_ff  <= 8'h00;
    end
    else if (~ovalid_ff | byte_ready_in)
    begin
      ovalid_ff <= pop_valid;
      if (pop_valid)
        obyte_ff <= pop_data;
    end
  end
  assign ev_ready_out   = rdy_ff;
  assign drop_out       = drop_ff;
  assign byte_valid_out = ovalid_ff;
  assign byte_data_out  = obyte_ff;
endmodule

//--- ettp_checker.sv
// --------------------------------
// event and stream port checker
// --------------------------------
module ettp_checker (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       ev_valid_in,
  input wire logic       ev_ready_out,
  input wire logic       ev_is_commit_in,
  input wire logic [4:0] exc_type_in,
  input wire logic [1:0] elem_sel_in,
  input wire logic       drop_out,
  input wire logic       byte_valid_out,
  input wire logic       byte_ready_in,
  input wire logic [7:0] byte_data_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // exception taken at this edge
  wire logic ex = ev_valid_in & ev_ready_out & !ev_is_commit_in;
  property p_hold;
    byte_valid_out & !byte_ready_in |=> byte_valid_out & $stable(byte_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("byte not held");
  property p_cmt;
    ev_valid_in & ev_ready_out & ev_is_commit_in |=> !drop_out & !ev_ready_out;
  endproperty
  a_cmt: assert property (p_cmt) else $error("commit refused");
  property p_sel;
    ex & (elem_sel_in == 2'h0 | elem_sel_in == 2'h3) |=> drop_out;
  endproperty
  a_sel: assert property (p_sel) else $error("bad select sent");
  property p_txf;
    ex & exc_type_in == 5'h18 |=> drop_out;
  endproperty
  a_txf: assert property (p_txf) else $error("fail type sent");
  property p_ok;
    ex & elem_sel_in == 2'h1 & exc_type_in < 5'h02 |=> !drop_out & !ev_ready_out;
  endproperty
  a_ok: assert property (p_ok) else $error("legal event refused");
  property p_impl;
    ex & elem_sel_in == 2'h2 & exc_type_in[4:3] == 2'h2 |=> !drop_out;
  endproperty
  a_impl: assert property (p_impl) else $error("impl type refused");
  property p_why;
    drop_out |-> $past(ex);
  endproperty
  a_why: assert property (p_why) else $error("drop without event");
  property p_keep;
    drop_out |-> ev_ready_out;
  endproperty
  a_keep: assert property (p_keep) else $error("ready lost on drop");
endmodule
bind ettp_encoder ettp_checker u_chk (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .ev_valid_in(ev_valid_in),
  .ev_ready_out(ev_ready_out),
  .ev_is_commit_in(ev_is_commit_in),
  .exc_type_in(exc_type_in),
  .elem_sel_in(elem_sel_in),
  .drop_out(drop_out),
  .byte_valid_out(byte_valid_out),
  .byte_ready_in(byte_ready_in),
  .byte_data_out(byte_data_out)
);

//--- ettp_sink.sv
// --------------------------------
// trace sink model
// --------------------------------
module ettp_sink (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       byte_valid_in,
  input  wire logic [7:0] byte_data_in,
  output wire logic       byte_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_ff;  // slow mode phase
  logic [7:0] got[$]; // bytes taken, oldest first
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      ph_ff <= 2'h0;
    else
      ph_ff <= ph_ff + 2'h1;
  // mode 0 prompt, 1 one beat in four, 2 stalled
  assign byte_ready_out = mode_in == 2'h0 | (mode_in == 2'h1 & ph_ff == 2'h3);
  always @(posedge clk_in)
    if (byte_valid_in & byte_ready_out)
      got.push_back(byte_data_in);
endmodule

//--- testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        ev_valid_in = 1'b0;
  logic        ev_is_commit_in = 1'b0;
  logic [4:0]  exc_type_in = 5'h00;
  logic [1:0]  elem_sel_in = 2'h1;
  logic [31:0] ret_addr_in = 32'h0;
  logic [31:0] h[3] = '{32'h1234_5678, 32'h0000_1000, 32'h0000_2000};
  logic [1:0]  mode = 2'h0;
  wire         ev_ready_out;
  wire         drop_out;
  wire         byte_valid_out;
  wire         byte_ready_in;
  wire  [7:0]  byte_data_out;
  int          errors = 0;
  int          checks_done = 0;
  logic [7:0]  exp[$];
  always #12.5 clk_in = ~clk_in;
  ettp_encoder dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ev_valid_in(ev_valid_in),
    .ev_ready_out(ev_ready_out), .ev_is_commit_in(ev_is_commit_in),
    .exc_type_in(exc_type_in), .elem_sel_in(elem_sel_in), .ret_addr_in(ret_addr_in),
    .hist0_in(h[0]), .hist1_in(h[1]), .hist2_in(h[2]), .drop_out(drop_out),
    .byte_valid_out(byte_valid_out), .byte_ready_in(byte_ready_in),
    .byte_data_out(byte_data_out));
  ettp_sink snk (.clk_in(clk_in), .rst_n_in(rst_n_in), .mode_in(mode),
    .byte_valid_in(byte_valid_out), .byte_data_in(byte_data_out),
    .byte_ready_out(byte_ready_in));
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want)
    begin
      errors++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  // offer one event; a long wait that runs out ends the run
  task automatic send(input logic c, input logic [4:0] t, input logic [1:0] e,
    input logic [31:0] r, input int lim, output logic ok);
    @(posedge clk_in);
    ev_is_commit_in <= c;
    exc_type_in <= t;
    elem_sel_in <= e;
    ret_addr_in <= r;
    ev_valid_in <= 1'b1;
    ok = 1'b0;
    // ready is read between edges, so the edge that follows is the take
    for (int n = 0; n < lim && !ok; n++)
    begin
      #1;
      ok = ev_ready_out;
      @(posedge clk_in);
    end
    ev_valid_in <= 1'b0;
    if (!ok && lim > 8)
    begin
      errors++;
      conclude();
    end
    #1;
  endtask
  // compare collected bytes with the expected queue
  task automatic drain;
    int n;
    n = 0;
    while (snk.got.size() < exp.size() && n < 900)
    begin
      @(posedge clk_in);
      n++;
    end
    // a stream that never delivers ends the run
    if (n >= 900)
    begin
      errors++;
      conclude();
    end
    repeat (6) @(posedge clk_in);
    chk(snk.got.size(), exp.size());
    foreach (exp[i])
      if (i < snk.got.size())
        chk(snk.got[i], exp[i]);
    exp.delete();
    snk.got.delete();
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_commit;
    logic ok;
    mode <= 2'h1;
    repeat (3)
    begin
      send(1'b1, 5'h18, 2'h0, 32'h0, 40, ok);
      chk(drop_out, 1'b0);
      exp.push_back(8'h0E);
    end
    drain();
    $display("commit test done");
  endtask
  // every type code, every selector, both element forms
  task automatic t_exact;
    logic ok;
    logic lg;
    mode <= 2'h0;
    for (int i = 0; i < 34; i++)
    begin
      lg = i < 32 && i != 5 && i != 8 && i != 9 && i != 13 && i < 24;
      send(1'b0, i[4:0], i < 32 ? 2'(1 + i % 2) : 2'(3 * (i - 32)), h[i % 3], 40, ok);
      chk(drop_out, !lg);
      if (lg)
      begin
        exp.push_back(8'h90 | 8'(i % 3));
        exp.push_back({2'(1 + i % 2), 1'b0, i[4:0]});
      end
    end
    drain();
    $display("exact test done");
  endtask
  // each address group length from one to five bytes
  task automatic t_short;
    logic ok;
    logic [29:0] a;
    int n;
    mode <= 2'h1;
    for (int k = 0; k < 5; k++)
    begin
      a = h[0][31:2] ^ (30'h1 << 7 * k);
      send(1'b0, 5'h0F, 2'h2, {a, 2'h0}, 40, ok);
      chk(drop_out, 1'b0);
      n = k + 1;
      exp.push_back(8'hA0);
      // target then exception select, type fifteen
      exp.push_back(8'h8F);
      for (int j = 0; j < n; j++)
        exp.push_back({j < n - 1, 7'(a >> 7 * j)});
    end
    drain();
    $display("short test done");
  endtask
  // stalled sink until events are held off, then drain
  task automatic t_fill;
    logic ok;
    int k;
    mode <= 2'h2;
    ok = 1'b1;
    for (k = 0; ok && k < 64; k++)
      send(1'b1, 5'h00, 2'h1, 32'h0, 8, ok);
    // fifo depth, plus the output stage and the packet parked in the packer
    chk(k - 1, 32 + 2);
    chk(ev_ready_out, 1'b0);
    repeat (k - 1) exp.push_back(8'h0E);
    mode <= 2'h0;
    drain();
    $display("fill test done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_commit();
    t_exact();
    t_short();
    t_fill();
    conclude();
  end
endmodule
